// ---- logic/dcw_store.sv ----
// dcw_store: write-once configuration words behind the table path,
// with decoded protection settings and a program write check.
// assumes reset is the power-on reset and inputs are synchronous.
`timescale 1ns/100ps
`include "dcw_map.svh"

// Functional notes
// - programmed bit reads 0, unprogrammed bit reads 1.
// - first configuration word sits at the fixed base address.
// - words reachable only by table read/write in config space.
// - upper byte of each word ignores writes; no bits there.
// - each programmed bit refuses a further write of 0 this power cycle; a 1 there is not refused.
// - twelve words at even addresses, boot through user id byte 3.
// - reserved bits read one; host writes them as one.
// - unimplemented bit positions read zero.
// - boot write-protect one permits boot writes, zero blocks them.
// - boot size code x11 means none; other codes set segment end.
// - size codes 1xx standard security, 0xx high security.
// - boot RAM code 00 is 1024, 01 256, 10 128 bytes.
// - secure write-protect one permits secure writes, zero blocks.
// - general write-protect zero blocks user program memory writes.
module dcw_store (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // table read and table write path
   input  wire dcw_pkg::dcw_tbl_req_s tbl_req,
   output logic                    tbl_ack,
   output logic [15:0]             tbl_rdata,
   output logic                    tbl_refused,
   // program memory write check
   input  wire logic               flash_wr_req,
   input  wire logic [23:0]        flash_wr_addr,
   output logic                    flash_wr_allow,
   output logic                    flash_wr_block,
   // decoded configuration
   output dcw_pkg::dcw_cfg_s       cfg,
   output dcw_pkg::dcw_sec_e       boot_sec,
   output logic [23:0]             boot_seg_end,
   output logic [10:0]             boot_ram_bytes,
   output dcw_pkg::dcw_sec_e       secure_sec,
   output logic [23:0]             secure_seg_end,
   output dcw_pkg::dcw_sec_e       general_sec
);
   import dcw_pkg::*;

   logic [7:0]  prog [12];
   logic [7:0]  next_prog [12];
   logic        next_tbl_ack;
   logic [15:0] next_tbl_rdata;
   logic        next_tbl_refused;
   logic        next_flash_wr_allow;
   logic        next_flash_wr_block;
   dcw_cfg_s    next_cfg;
   dcw_sec_e    next_boot_sec;
   logic [23:0] next_boot_seg_end;
   logic [10:0] next_boot_ram_bytes;
   dcw_sec_e    next_secure_sec;
   logic [23:0] next_secure_seg_end;
   dcw_sec_e    next_general_sec;

   logic        hit;
   logic [3:0]  idx;
   logic [23:0] rel;
   logic [7:0]  attempt;
   logic [7:0]  w_boot;
   logic [7:0]  w_sec;
   logic [7:0]  w_gen;
   logic        in_boot;
   logic        in_secure;

   function automatic logic [7:0] impl_mask(input logic [3:0] i);
      case (i)
         4'h0:    impl_mask = `DCW_IMPL_BOOT;
         4'h1:    impl_mask = `DCW_IMPL_SECURE;
         4'h2:    impl_mask = `DCW_IMPL_GENERAL;
         4'h3:    impl_mask = `DCW_IMPL_OSCSEL;
         4'h4:    impl_mask = `DCW_IMPL_OSC;
         4'h5:    impl_mask = `DCW_IMPL_WDOG;
         4'h6:    impl_mask = `DCW_IMPL_POR;
         4'h8,
         4'h9,
         4'hA,
         4'hB:    impl_mask = `DCW_IMPL_UID;
         default: impl_mask = 8'h00;
      endcase
   endfunction : impl_mask

   // read value of one word from its programmed mask
   function automatic logic [7:0] word_val(input logic [3:0] i,
                                           input logic [7:0] p);
      if (i == `DCW_IDX_RSVD) begin
         word_val = `DCW_RSVD_VAL;
      end else begin
         word_val = impl_mask(i) & ~p;
      end
   endfunction : word_val

   always_comb begin
      rel       = tbl_req.addr - `DCW_BASE;
      idx       = rel[4:1];
      hit       = (tbl_req.addr >= `DCW_CFG_LO)
                  && (tbl_req.addr >= `DCW_OFS_BOOT)
                  && (tbl_req.addr <= `DCW_OFS_UID3)
                  && !tbl_req.addr[0];
      attempt   = 8'h00;
      w_boot    = word_val(`DCW_IDX_BOOT, prog[0]);
      w_sec     = word_val(`DCW_IDX_SECURE, prog[1]);
      w_gen     = word_val(`DCW_IDX_GENERAL, prog[2]);
      next_prog = prog;
      next_tbl_ack     = tbl_req.rd | tbl_req.wr;
      next_tbl_rdata   = tbl_rdata;
      next_tbl_refused = 1'b0;

      if (tbl_req.rd) begin
         if (hit) begin
            next_tbl_rdata = {`DCW_UPPER_RD, word_val(idx, prog[idx])};
         end else begin
            next_tbl_rdata = 16'h0000;
         end
      end

      if (tbl_req.wr) begin
         if (!hit || idx == `DCW_IDX_RSVD) begin
            next_tbl_refused = 1'b1;
         end else begin
            // upper byte dropped; a 0 in the low byte programs a bit
            attempt = ~tbl_req.wdata[7:0] & impl_mask(idx);
            if ((attempt & prog[idx]) != 8'h00) begin
               next_tbl_refused = 1'b1;
            end
            next_prog[idx] = prog[idx] | attempt;
         end
      end

      // decoded fields
      next_cfg.boot_write_protect       = w_boot[`DCW_WRP_BIT];
      next_cfg.boot_segment_size_sel    = w_boot[`DCW_SSZ_LSB +: 3];
      next_cfg.boot_ram_size_sel        = w_boot[`DCW_RSZ_LSB +: 2];
      next_cfg.secure_write_protect     = w_sec[`DCW_WRP_BIT];
      next_cfg.secure_segment_size_sel  = w_sec[`DCW_SSZ_LSB +: 3];
      next_cfg.general_write_protect    = w_gen[`DCW_WRP_BIT];
      next_cfg.general_code_protect_sel = w_gen[`DCW_GCP_LSB +: 2];

      // boot segment size and security
      case (next_cfg.boot_segment_size_sel[1:0])
         2'b10:   next_boot_seg_end = `DCW_BOOT_END_1K;
         2'b01:   next_boot_seg_end = `DCW_BOOT_END_4K;
         2'b00:   next_boot_seg_end = `DCW_BOOT_END_8K;
         default: next_boot_seg_end = 24'h000000;
      endcase
      if (next_cfg.boot_segment_size_sel[1:0] == 2'b11) begin
         next_boot_sec = DCW_SEC_NONE;
      end else if (next_cfg.boot_segment_size_sel[2]) begin
         next_boot_sec = DCW_SEC_STD;
      end else begin
         next_boot_sec = DCW_SEC_HIGH;
      end

      case (next_cfg.boot_ram_size_sel)
         2'b10:   next_boot_ram_bytes = `DCW_BRAM_128;
         2'b01:   next_boot_ram_bytes = `DCW_BRAM_256;
         2'b00:   next_boot_ram_bytes = `DCW_BRAM_1024;
         default: next_boot_ram_bytes = `DCW_BRAM_NONE;
      endcase

      // secure segment size and security
      case (next_cfg.secure_segment_size_sel[1:0])
         2'b10:   next_secure_seg_end = `DCW_SEC_END_8K;
         2'b01:   next_secure_seg_end = `DCW_SEC_END_16K;
         2'b00:   next_secure_seg_end = `DCW_SEC_END_32K;
         default: next_secure_seg_end = 24'h000000;
      endcase
      if (next_cfg.secure_segment_size_sel[1:0] == 2'b11) begin
         next_secure_sec = DCW_SEC_NONE;
      end else if (next_cfg.secure_segment_size_sel[2]) begin
         next_secure_sec = DCW_SEC_STD;
      end else begin
         next_secure_sec = DCW_SEC_HIGH;
      end

      if (next_cfg.general_code_protect_sel == 2'b11) begin
         next_general_sec = DCW_SEC_NONE;
      end else if (next_cfg.general_code_protect_sel == 2'b10) begin
         next_general_sec = DCW_SEC_STD;
      end else begin
         next_general_sec = DCW_SEC_HIGH;
      end

      // program memory write check, boot before secure before general
      in_boot   = (next_boot_sec != DCW_SEC_NONE)
                  && (flash_wr_addr <= next_boot_seg_end);
      in_secure = (next_secure_sec != DCW_SEC_NONE)
                  && (flash_wr_addr <= next_secure_seg_end);
      next_flash_wr_allow = 1'b0;
      next_flash_wr_block = 1'b0;
      if (flash_wr_req) begin
         if (in_boot) begin
            next_flash_wr_allow = next_cfg.boot_write_protect;
         end else if (in_secure) begin
            next_flash_wr_allow = next_cfg.secure_write_protect;
         end else begin
            next_flash_wr_allow = next_cfg.general_write_protect;
         end
         next_flash_wr_block = ~next_flash_wr_allow;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         // only power-on reset re-arms programming
         for (int i = 0; i < 12; i++) begin
            prog[i] <= `DCW_PROG_RST;
         end
         tbl_ack        <= 1'b0;
         tbl_rdata      <= 16'h0000;
         tbl_refused    <= 1'b0;
         flash_wr_allow <= 1'b0;
         flash_wr_block <= 1'b0;
         cfg            <= '1;
         boot_sec       <= DCW_SEC_NONE;
         boot_seg_end   <= 24'h000000;
         boot_ram_bytes <= `DCW_BRAM_NONE;
         secure_sec     <= DCW_SEC_NONE;
         secure_seg_end <= 24'h000000;
         general_sec    <= DCW_SEC_NONE;
      end else begin
         prog           <= next_prog;
         tbl_ack        <= next_tbl_ack;
         tbl_rdata      <= next_tbl_rdata;
         tbl_refused    <= next_tbl_refused;
         flash_wr_allow <= next_flash_wr_allow;
         flash_wr_block <= next_flash_wr_block;
         cfg            <= next_cfg;
         boot_sec       <= next_boot_sec;
         boot_seg_end   <= next_boot_seg_end;
         boot_ram_bytes <= next_boot_ram_bytes;
         secure_sec     <= next_secure_sec;
         secure_seg_end <= next_secure_seg_end;
         general_sec    <= next_general_sec;
      end
   end
endmodule : dcw_store

// ---- logic/dcw_map.svh ----
// dcw_map.svh: addresses, field positions, reset values and sizes
// of the configuration word store; assumes 24-bit table addresses.
`ifndef DCW_MAP_SVH
`define DCW_MAP_SVH
// configuration space and word addresses
`define DCW_CFG_LO       24'h800000
`define DCW_BASE         24'hF80000
`define DCW_OFS_BOOT     24'hF80000
`define DCW_OFS_SECURE   24'hF80002
`define DCW_OFS_GENERAL  24'hF80004
`define DCW_OFS_OSCSEL   24'hF80006
`define DCW_OFS_OSC      24'hF80008
`define DCW_OFS_WDOG     24'hF8000A
`define DCW_OFS_POR      24'hF8000C
`define DCW_OFS_RSVD     24'hF8000E
`define DCW_OFS_UID0     24'hF80010
`define DCW_OFS_UID1     24'hF80012
`define DCW_OFS_UID2     24'hF80014
`define DCW_OFS_UID3     24'hF80016
// word indices
`define DCW_IDX_BOOT     4'h0
`define DCW_IDX_SECURE   4'h1
`define DCW_IDX_GENERAL  4'h2
`define DCW_IDX_RSVD     4'h7
// implemented bits per word
`define DCW_IMPL_BOOT    8'hCF
`define DCW_IMPL_SECURE  8'hCF
`define DCW_IMPL_GENERAL 8'h07
`define DCW_IMPL_OSCSEL  8'h87
`define DCW_IMPL_OSC     8'hC7
`define DCW_IMPL_WDOG    8'hDF
`define DCW_IMPL_POR     8'hE7
`define DCW_IMPL_UID     8'hFF
`define DCW_RSVD_VAL     8'hFF
`define DCW_PROG_RST     8'h00
`define DCW_UPPER_RD     8'h00
// field positions
`define DCW_WRP_BIT      0
`define DCW_SSZ_LSB      1
`define DCW_RSZ_LSB      6
`define DCW_GCP_LSB      1
// segment ends in instruction-word addresses
`define DCW_BOOT_END_1K  24'h0007FE
`define DCW_BOOT_END_4K  24'h001FFE
`define DCW_BOOT_END_8K  24'h003FFE
`define DCW_SEC_END_8K   24'h003FFE
`define DCW_SEC_END_16K  24'h007FFE
`define DCW_SEC_END_32K  24'h00FFFE
// boot RAM sizes in bytes
`define DCW_BRAM_NONE    11'h000
`define DCW_BRAM_128     11'h080
`define DCW_BRAM_256     11'h100
`define DCW_BRAM_1024    11'h400
`endif

// ---- logic/dcw_pkg.sv ----
// dcw_pkg: types shared by the configuration word store and its users.
// assumes dcw_map.svh supplies all numeric constants.
package dcw_pkg;
   typedef enum logic [1:0] {
      DCW_SEC_NONE = 2'b00,
      DCW_SEC_STD  = 2'b01,
      DCW_SEC_HIGH = 2'b10
   } dcw_sec_e;

   // one table read or table write request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [23:0] addr;
      logic [15:0] wdata;
   } dcw_tbl_req_s;

   // decoded protection fields
   typedef struct packed {
      logic       boot_write_protect;
      logic [2:0] boot_segment_size_sel;
      logic [1:0] boot_ram_size_sel;
      logic       secure_write_protect;
      logic [2:0] secure_segment_size_sel;
      logic       general_write_protect;
      logic [1:0] general_code_protect_sel;
   } dcw_cfg_s;
endpackage : dcw_pkg

// ---- dv/dcw_store_monitor.sv ----
// dcw_store_monitor: table path and decode checks on the store ports.
// assumes it is bound into every dcw_store instance.
`timescale 1ns/100ps
module dcw_store_monitor (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  reset,
   // table path
   input wire dcw_pkg::dcw_tbl_req_s tbl_req,
   input wire logic                  tbl_ack,
   input wire logic [15:0]           tbl_rdata,
   input wire logic                  tbl_refused,
   // flash check
   input wire logic                  flash_wr_req,
   input wire logic                  flash_wr_allow,
   input wire logic                  flash_wr_block,
   // decoded fields
   input wire dcw_pkg::dcw_cfg_s     cfg,
   input wire dcw_pkg::dcw_sec_e     boot_sec,
   input wire logic [23:0]           boot_seg_end,
   input wire logic [10:0]           boot_ram_bytes
);
   import dcw_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_req; tbl_req.rd || tbl_req.wr; endsequence
   sequence s_rsvd; tbl_req.addr == 24'hF8000E; endsequence
   property p_ack; s_req |=> tbl_ack; endproperty
   property p_idle; !(tbl_req.rd || tbl_req.wr) |=> !tbl_ack && !tbl_refused;
   endproperty
   property p_upper; tbl_ack |-> tbl_rdata[15:8] == 8'h00; endproperty
   property p_rsvd_wr; tbl_req.wr ##0 s_rsvd |=> tbl_refused; endproperty
   property p_rsvd_rd; tbl_req.rd ##0 s_rsvd |=> tbl_rdata == 16'h00FF;
   endproperty
   property p_low; tbl_req.wr && tbl_req.addr < 24'h800000 |=> tbl_refused;
   endproperty
   property p_flash; flash_wr_req |=> flash_wr_allow != flash_wr_block;
   endproperty
   property p_boot; cfg.boot_segment_size_sel[1:0] == 2'b11
      |-> boot_sec == DCW_SEC_NONE && boot_seg_end == 24'h000000; endproperty
   property p_bram; cfg.boot_ram_size_sel == 2'b00
      |-> boot_ram_bytes == 11'h400; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   a_idle: assert property (p_idle) else $error("stray ack");
   a_upper: assert property (p_upper) else $error("upper byte");
   a_rsvd_wr: assert property (p_rsvd_wr) else $error("rsvd wr");
   a_rsvd_rd: assert property (p_rsvd_rd) else $error("rsvd rd");
   a_low: assert property (p_low) else $error("low addr wr");
   a_flash: assert property (p_flash) else $error("flash answer");
   a_boot: assert property (p_boot) else $error("boot none");
   a_bram: assert property (p_bram) else $error("boot ram");
endmodule : dcw_store_monitor
bind dcw_store dcw_store_monitor dcw_store_monitor_inst (.clk, .reset,
   .tbl_req, .tbl_ack, .tbl_rdata, .tbl_refused, .flash_wr_req,
   .flash_wr_allow, .flash_wr_block, .cfg, .boot_sec, .boot_seg_end,
   .boot_ram_bytes);

// ---- dv/dcw_host_model.sv ----
// dcw_host_model: processor table read/write path.
// assumes one request per call, taken at the next rising edge.
`timescale 1ns/100ps
module dcw_host_model (
   // table path
   input wire logic              clk,
   output dcw_pkg::dcw_tbl_req_s req,
   input wire logic              ack,
   input wire logic [15:0]       rdata,
   input wire logic              refused
);
   import dcw_pkg::*;
   initial req = '{1'b0, 1'b0, 24'h000000, 16'h0000};
   task xfer(input logic rd, input logic wr, input logic [23:0] a,
             input logic [15:0] d, output logic [15:0] q,
             output logic r, output logic k);
      @(posedge clk);
      #1 req = '{rd, wr, a, d};
      @(posedge clk);
      // released lines show inverted values
      #1 req = '{1'b0, 1'b0, ~a, ~d};
      q = rdata;
      r = refused;
      k = ack;
   endtask : xfer
endmodule : dcw_host_model

// ---- dv/testbench.sv ----
// testbench: table read/write sequences against dcw_store.
// assumes dcw_host_model drives the table path.
`timescale 1ns/100ps
module testbench;
   import dcw_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   dcw_tbl_req_s tbl_req;
   logic tbl_ack, tbl_refused, k, r;
   logic [15:0] tbl_rdata, q;
   logic flash_wr_req = 1'b0;
   logic [23:0] flash_wr_addr = 24'h000000;
   logic flash_wr_allow, flash_wr_block;
   dcw_cfg_s cfg;
   dcw_sec_e boot_sec, secure_sec, general_sec;
   logic [23:0] boot_seg_end, secure_seg_end;
   logic [10:0] boot_ram_bytes;
   int err_total = 0;
   int checks = 0;
   logic [7:0] mask [12] = '{8'hCF, 8'hCF, 8'h07, 8'h87, 8'hC7, 8'hDF,
      8'hE7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   always #4 clk = ~clk;
   dcw_store dcw_store_inst (.clk, .reset, .tbl_req, .tbl_ack, .tbl_rdata,
      .tbl_refused, .flash_wr_req, .flash_wr_addr, .flash_wr_allow,
      .flash_wr_block, .cfg, .boot_sec, .boot_seg_end, .boot_ram_bytes,
      .secure_sec, .secure_seg_end, .general_sec);
   dcw_host_model dcw_host_model_inst (.clk, .req(tbl_req), .ack(tbl_ack),
      .rdata(tbl_rdata), .refused(tbl_refused));
   task chk(input string n, input logic [23:0] s, input logic [23:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task results;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   task wr(input logic [23:0] a, input logic [15:0] d, input logic e);
      dcw_host_model_inst.xfer(1'b0, 1'b1, a, d, q, r, k);
      chk("ack", 24'(k), 24'h1);
      chk("refused", 24'(r), 24'(e));
   endtask : wr
   task rd(input logic [23:0] a, input logic [15:0] e);
      dcw_host_model_inst.xfer(1'b1, 1'b0, a, 16'h0000, q, r, k);
      chk("rdata", 24'(q), 24'(e));
   endtask : rd
   task fl(input logic [23:0] a, input logic b);
      @(posedge clk);
      #1 flash_wr_req = 1'b1;
      flash_wr_addr = a;
      @(posedge clk);
      #1 flash_wr_req = 1'b0;
      flash_wr_addr = ~a;
      chk("block", 24'(flash_wr_block), 24'(b));
      chk("allow", 24'(flash_wr_allow), 24'(!b));
   endtask : fl
   initial begin
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      for (int i = 0; i < 12; i++) begin
         rd(24'hF80000 + 24'(2 * i), {8'h00, mask[i]});
      end
      chk("bram", 24'(boot_ram_bytes), 24'h000000);
      chk("boot_sec", 24'(boot_sec), 24'(DCW_SEC_NONE));
      chk("sec_sec", 24'(secure_sec), 24'(DCW_SEC_NONE));
      chk("gen_sec", 24'(general_sec), 24'(DCW_SEC_NONE));
      $display("test erased read done");
      wr(24'hF80002, 16'hFFFC, 1'b0);
      wr(24'hF80000, 16'hFFFD, 1'b0);
      rd(24'hF80000, 16'h00CD);
      chk("boot_end", boot_seg_end, 24'h0007FE);
      chk("boot_sec", 24'(boot_sec), 24'(DCW_SEC_STD));
      chk("sec_end", secure_seg_end, 24'h003FFE);
      chk("sec_sec", 24'(secure_sec), 24'(DCW_SEC_STD));
      fl(24'h000100, 1'b0);
      fl(24'h000900, 1'b1);
      fl(24'h008000, 1'b0);
      wr(24'hF80004, 16'hFFFE, 1'b0);
      fl(24'h008000, 1'b1);
      chk("gwp", 24'(cfg.general_write_protect), 24'h0);
      chk("gen_sec", 24'(general_sec), 24'(DCW_SEC_NONE));
      rd(24'hF80004, 16'h0006);
      wr(24'hF80004, 16'hFFFE, 1'b1);
      wr(24'hF80000, 16'hFFF7, 1'b0);
      wr(24'hF80000, 16'hFFBF, 1'b0);
      @(posedge clk);
      #1 chk("boot_sec", 24'(boot_sec), 24'(DCW_SEC_HIGH));
      chk("bram", 24'(boot_ram_bytes), 24'h000080);
      wr(24'hF80000, 16'hFF7F, 1'b0);
      @(posedge clk);
      #1 chk("bram", 24'(boot_ram_bytes), 24'h000400);
      wr(24'hF80010, 16'h00FF, 1'b0);
      rd(24'hF80010, 16'h00FF);
      wr(24'hF8000E, 16'hFFFF, 1'b1);
      wr(24'hF80011, 16'hFFFE, 1'b1);
      wr(24'h001000, 16'hFFFE, 1'b1);
      rd(24'hF80018, 16'h0000);
      $display("test programming done");
      @(posedge clk);
      #1 reset = 1'b1;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      rd(24'hF80004, 16'h0007);
      wr(24'hF80004, 16'hFFFE, 1'b0);
      wr(24'hF80002, 16'hFFFB, 1'b0);
      wr(24'hF80000, 16'hFFFB, 1'b0);
      wr(24'hF80004, 16'hFFFD, 1'b0);
      @(posedge clk);
      #1 chk("sec_end", secure_seg_end, 24'h007FFE);
      chk("sec_sec", 24'(secure_sec), 24'(DCW_SEC_STD));
      chk("boot_end", boot_seg_end, 24'h001FFE);
      chk("gen_sec", 24'(general_sec), 24'(DCW_SEC_STD));
      $display("test power cycle done");
      results();
   end
   // about 80 cycles of traffic; allow about thirty times that
   initial begin
      #20000;
      err_total++;
      results();
   end
endmodule : testbench
